// *** hdl/pqw_pkg.sv ***
// package of register offsets, field layouts, reset values and counts for the
// port queue weight and rate accounting block
// assumes a 32-bit apb slave, byte addresses are four times the register index
package pqw_pkg;
   localparam int NPORT = 4;
   localparam int NQ = 4;
   // register indices as printed
   localparam logic [7:0] IDX_P1_Q0_WEIGHT = 8'hC5;
   localparam logic [7:0] IDX_P2_Q0_WEIGHT = 8'hD5;
   localparam logic [7:0] IDX_P3_Q0_WEIGHT = 8'hE5;
   localparam logic [7:0] IDX_P4_Q0_WEIGHT = 8'hF5;
   localparam logic [7:0] IDX_P1_Q1_WEIGHT = 8'hC4;
   localparam logic [7:0] IDX_RATE_ACC_A = 8'hD6;
   localparam logic [7:0] IDX_RATE_ACC_B = 8'hE6;
   localparam logic [7:0] IDX_RATE_ACC_C = 8'hF6;
   localparam logic [7:0] IDX_P1_SPLIT = 8'hC1;
   localparam logic [7:0] IDX_STATUS = 8'hC0;
   localparam logic [7:0] PORT_STRIDE = 8'h10;
   // field positions
   localparam int WEN_BIT = 7;
   localparam int FC_EN_BIT = 4;
   localparam int MODE_LSB = 2;
   localparam int GAP_BIT = 1;
   localparam int PRE_BIT = 0;
   // reset values
   localparam logic [7:0] Q0_WEIGHT_RST = 8'h81;
   localparam logic [7:0] Q1_WEIGHT_RST = 8'h82;
   localparam logic [4:0] RATE_ACC_RST = 5'h00;
   localparam logic [1:0] SPLIT_RST = 2'h0;
   // per-frame byte adders
   localparam logic [4:0] GAP_BYTES = 5'h0C;
   localparam logic [4:0] PRE_BYTES = 5'h08;
   // split encodings
   localparam logic [1:0] SPLIT_ONE = 2'h0;
   localparam logic [1:0] SPLIT_TWO = 2'h1;
   localparam logic [1:0] SPLIT_FOUR = 2'h2;
   // ingress limit modes
   typedef enum logic [1:0] {
      LIM_ALL = 2'b00,
      LIM_BC_MC_FLOOD = 2'b01,
      LIM_BC_MC = 2'b10,
      LIM_BC = 2'b11
   } pqw_lim_t;
   typedef enum logic [1:0] {
      SCH_IDLE = 2'b00,
      SCH_SEND = 2'b01
   } pqw_sch_t;
endpackage : pqw_pkg

// *** hdl/pqw_sched.sv ***
// per-port egress queue selector, weighted or strict priority
// assumes tx_done pulses once per packet sent from the granted queue
module pqw_sched
   import pqw_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic resetn, // async reset, active low
   pqw_sched_if.sched s // settings and queue status
);
   typedef struct packed {
      pqw_sch_t st;
      logic [3:0] grant;
      logic [6:0] cnt0;
      logic [6:0] cnt1;
   } pqw_schs_t;
   pqw_schs_t r;
   pqw_schs_t nxt;
   logic [3:0] elig;
   logic [1:0] pick;
   logic found;
   logic [3:0] avail;

   // queues 2 and 3 are not weighted here, so they behave as strict priority
   always_comb begin
      // queue 1 carries high class in two-queue mode, low/high in four
      avail = s.pkt_avail;
      if (s.split == SPLIT_ONE) begin
         avail = {3'h0, |s.pkt_avail};
      end else if (s.split == SPLIT_TWO) begin
         avail = {2'h0, s.pkt_avail[1], s.pkt_avail[0] | 1'b0};
      end
      elig = avail;
      if (s.q0_wen && r.cnt0 >= s.q0_weight) begin
         elig[0] = 1'b0;
      end
      if (s.q1_wen && r.cnt1 >= s.q1_weight) begin
         elig[1] = 1'b0;
      end
      found = 1'b0;
      pick = 2'h0;
      // highest index wins; q0 strict drains before nothing lower exists
      for (int i = 0; i < NQ; i++) begin
         if (elig[i]) begin
            found = 1'b1;
            pick = 2'(i);
         end
      end
   end

   always_comb begin
      nxt = r;
      case (r.st)
         SCH_IDLE: begin
            if (found) begin
               nxt.grant = 4'h1 << pick;
               nxt.st = SCH_SEND;
            end else if (avail != 4'h0) begin
               // interval ends when every waiting queue used its share
               nxt.cnt0 = 7'h00;
               nxt.cnt1 = 7'h00;
            end
         end
         SCH_SEND: begin
            if (s.tx_done) begin
               if (r.grant[0]) begin
                  nxt.cnt0 = r.cnt0 + 7'h01;
               end
               if (r.grant[1]) begin
                  nxt.cnt1 = r.cnt1 + 7'h01;
               end
               nxt.grant = 4'h0;
               nxt.st = SCH_IDLE;
            end
         end
         default: begin
            nxt.st = SCH_IDLE;
            nxt.grant = 4'h0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{st: SCH_IDLE, grant: 4'h0, cnt0: 7'h00, cnt1: 7'h00};
      end else begin
         r <= nxt;
      end
   end

   assign s.grant = r.grant;

   a_grant_onehot: assert property (@(posedge clk) disable iff (!resetn)
      $onehot0(r.grant)) else $error("grant not one-hot");
   a_q0_weight_cap: assert property (@(posedge clk) disable iff (!resetn)
      (s.q0_wen && r.cnt0 >= s.q0_weight && r.st == SCH_IDLE) |=> !r.grant[0])
      else $error("queue 0 exceeded its weight");
   a_q1_weight_cap: assert property (@(posedge clk) disable iff (!resetn)
      (s.q1_wen && r.cnt1 >= s.q1_weight && r.st == SCH_IDLE) |=> !r.grant[1])
      else $error("queue 1 exceeded its weight");
endmodule : pqw_sched

// *** hdl/pqw_sched_if.sv ***
// interface carrying one port's scheduler settings and queue status
// assumes the same clock as the register file
interface pqw_sched_if;
   logic [1:0] split;
   logic q0_wen;
   logic [6:0] q0_weight;
   logic q1_wen;
   logic [6:0] q1_weight;
   logic [3:0] pkt_avail;
   logic tx_done;
   logic [3:0] grant;
   modport cfg (output split, q0_wen, q0_weight, q1_wen, q1_weight, pkt_avail, tx_done,
                input grant);
   modport sched (input split, q0_wen, q0_weight, q1_wen, q1_weight, pkt_avail, tx_done,
                  output grant);
endinterface : pqw_sched_if

// *** hdl/pqw_top.sv ***
// register file and rate accounting for four ports, plus one port scheduler
// assumes an apb master on clk; frame events come from the same clock domain
//
// Added by the designer: register access over APB.
module pqw_top
   import pqw_pkg::*;
(
   input wire logic clk, // core clock, 10 MHz
   input wire logic resetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [1:0] rx_port, // port of received frame
   input wire logic rx_frame, // one-cycle pulse per received frame
   input wire logic [10:0] rx_len, // received frame length in bytes
   input wire logic rx_bcast, // frame is broadcast
   input wire logic rx_mcast, // frame is multicast
   input wire logic rx_flood, // frame is flooded unicast
   input wire logic [3:0] rx_over, // ingress rate exceeded per port
   input wire logic [1:0] tx_port, // port of transmitted frame
   input wire logic tx_frame, // one-cycle pulse per transmitted frame
   input wire logic [10:0] tx_len, // transmitted frame length in bytes
   input wire logic [3:0] q_avail, // port 1 queue packet available
   input wire logic q_tx_done, // port 1 packet sent pulse
   output logic [3:0] q_grant, // port 1 queue grant
   output logic [3:0] flow_ctrl, // flow control request per port
   output logic rx_count_vld, // ingress count valid pulse
   output logic rx_counted, // frame counted against ingress limit
   output logic [11:0] rx_count_bytes, // ingress bytes to charge
   output logic [1:0] rx_count_port, // port of ingress charge
   output logic tx_count_vld, // egress count valid pulse
   output logic [11:0] tx_count_bytes, // egress bytes to charge
   output logic [1:0] tx_count_port // port of egress charge
);
   typedef struct packed {
      logic [NPORT-1:0][7:0] q0w;
      logic [7:0] q1w;
      logic [NPORT-1:0][4:0] acc;
      logic [1:0] split;
      logic [31:0] rdata;
      logic err;
      logic [3:0] fc;
      logic rv;
      logic rc;
      logic [11:0] rb;
      logic [1:0] rp;
      logic tv;
      logic [11:0] tb;
      logic [1:0] tp;
   } pqw_state_t;
   pqw_state_t r;
   pqw_state_t nxt;

   pqw_sched_if sif();

   // ===========================================================
   // apb decode
   logic wr_acc;
   logic rd_acc;
   logic [7:0] idx;
   logic hit;
   logic [31:0] rd_val;
   logic [2:0] port_sel;
   logic [3:0] rx_kind_ok;
   logic [4:0] rx_add;
   logic [4:0] tx_add;

   assign idx = paddr[9:2];
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;

   always_comb begin
      hit = 1'b1;
      rd_val = 32'h0000_0000;
      port_sel = 3'h4;
      case (idx)
         IDX_P1_Q0_WEIGHT: port_sel = 3'h0;
         IDX_P2_Q0_WEIGHT: port_sel = 3'h1;
         IDX_P3_Q0_WEIGHT: port_sel = 3'h2;
         IDX_P4_Q0_WEIGHT: port_sel = 3'h3;
         default: port_sel = 3'h4;
      endcase
      if (port_sel != 3'h4) begin
         rd_val = {24'h00_0000, r.q0w[port_sel[1:0]]};
      end else begin
         case (idx)
            IDX_P1_Q1_WEIGHT: rd_val = {24'h00_0000, r.q1w};
            // upper accounting bits are not stored and read as zero
            IDX_RATE_ACC_A: rd_val = {27'h000_0000, r.acc[1]};
            IDX_RATE_ACC_B: rd_val = {27'h000_0000, r.acc[2]};
            IDX_RATE_ACC_C: rd_val = {27'h000_0000, r.acc[3]};
            (IDX_RATE_ACC_A - PORT_STRIDE): rd_val = {27'h000_0000, r.acc[0]};
            IDX_P1_SPLIT: rd_val = {30'h0000_0000, r.split};
            IDX_STATUS: rd_val = {24'h00_0000, r.fc, q_grant};
            default: hit = 1'b0;
         endcase
      end
      if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
         hit = 1'b0;
      end
   end

   // ===========================================================
   // rate accounting per frame
   always_comb begin
      rx_kind_ok = 4'h0;
      rx_add = 5'h00;
      tx_add = 5'h00;
      case (pqw_lim_t'(r.acc[rx_port][MODE_LSB +: 2]))
         LIM_ALL: rx_kind_ok = 4'hF;
         LIM_BC_MC_FLOOD: rx_kind_ok = {3'h0, rx_bcast | rx_mcast | rx_flood};
         LIM_BC_MC: rx_kind_ok = {3'h0, rx_bcast | rx_mcast};
         LIM_BC: rx_kind_ok = {3'h0, rx_bcast};
         default: rx_kind_ok = 4'h0;
      endcase
      if (r.acc[rx_port][GAP_BIT]) begin
         rx_add = rx_add + GAP_BYTES;
      end
      if (r.acc[rx_port][PRE_BIT]) begin
         rx_add = rx_add + PRE_BYTES;
      end
      if (r.acc[tx_port][GAP_BIT]) begin
         tx_add = tx_add + GAP_BYTES;
      end
      if (r.acc[tx_port][PRE_BIT]) begin
         tx_add = tx_add + PRE_BYTES;
      end
   end

   // ===========================================================
   // next state
   always_comb begin
      nxt = r;
      nxt.err = 1'b0;
      // captured at the setup edge so the answer stands through the access cycle
      if (psel && !penable && !pwrite) begin
         nxt.rdata = hit ? rd_val : 32'h0000_0000;
      end
      if (psel && !penable) begin
         nxt.err = !hit;
      end
      if (wr_acc && hit) begin
         if (port_sel != 3'h4) begin
            nxt.q0w[port_sel[1:0]] = pwdata[7:0];
         end else begin
            case (idx)
               IDX_P1_Q1_WEIGHT: nxt.q1w = pwdata[7:0];
               IDX_RATE_ACC_A: nxt.acc[1] = pwdata[4:0];
               IDX_RATE_ACC_B: nxt.acc[2] = pwdata[4:0];
               IDX_RATE_ACC_C: nxt.acc[3] = pwdata[4:0];
               (IDX_RATE_ACC_A - PORT_STRIDE): nxt.acc[0] = pwdata[4:0];
               IDX_P1_SPLIT: begin
                  // reserved encoding is refused, old split stays
                  if (pwdata[1:0] != 2'h3) begin
                     nxt.split = pwdata[1:0];
                  end
               end
               default: nxt.split = r.split;
            endcase
         end
      end
      for (int p = 0; p < NPORT; p++) begin
         nxt.fc[p] = rx_over[p] && r.acc[p][FC_EN_BIT];
      end
      nxt.rv = rx_frame;
      nxt.rc = rx_frame && rx_kind_ok[0];
      nxt.rb = 12'(rx_len) + 12'(rx_add);
      nxt.rp = rx_port;
      nxt.tv = tx_frame;
      nxt.tb = 12'(tx_len) + 12'(tx_add);
      nxt.tp = tx_port;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         for (int p = 0; p < NPORT; p++) begin
            r.q0w[p] <= Q0_WEIGHT_RST;
            r.acc[p] <= RATE_ACC_RST;
         end
         r.q1w <= Q1_WEIGHT_RST;
         r.split <= SPLIT_RST;
      end else begin
         r <= nxt;
      end
   end

   // ===========================================================
   // outputs and scheduler
   assign sif.split = r.split;
   assign sif.q0_wen = r.q0w[0][WEN_BIT];
   assign sif.q0_weight = r.q0w[0][6:0];
   assign sif.q1_wen = r.q1w[WEN_BIT];
   assign sif.q1_weight = r.q1w[6:0];
   assign sif.pkt_avail = q_avail;
   assign sif.tx_done = q_tx_done;
   assign q_grant = sif.grant;

   pqw_sched u_sched (
      .clk(clk),
      .resetn(resetn),
      .s(sif.sched)
   );

   // zero-wait slave: answers in the first access cycle
   assign pready = 1'b1;
   assign prdata = r.rdata;
   assign pslverr = r.err;
   assign flow_ctrl = r.fc;
   assign rx_count_vld = r.rv;
   assign rx_counted = r.rc;
   assign rx_count_bytes = r.rb;
   assign rx_count_port = r.rp;
   assign tx_count_vld = r.tv;
   assign tx_count_bytes = r.tb;
   assign tx_count_port = r.tp;

   a_fc_gated: assert property (@(posedge clk) disable iff (!resetn)
      (rx_over[0] && !r.acc[0][FC_EN_BIT]) |=> !flow_ctrl[0])
      else $error("flow control raised while disabled");
   a_fc_raised: assert property (@(posedge clk) disable iff (!resetn)
      (rx_over[1] && r.acc[1][FC_EN_BIT]) |=> flow_ctrl[1])
      else $error("flow control not raised");
   a_bc_only: assert property (@(posedge clk) disable iff (!resetn)
      (rx_frame && !rx_bcast && r.acc[rx_port][3:2] == 2'b11) |=> !rx_counted)
      else $error("non-broadcast counted in broadcast mode");
   a_all_frames: assert property (@(posedge clk) disable iff (!resetn)
      (rx_frame && r.acc[rx_port][3:2] == 2'b00) |=> rx_counted)
      else $error("frame not counted in all-frames mode");
   a_gap_pre_add: assert property (@(posedge clk) disable iff (!resetn)
      (tx_frame && r.acc[tx_port][1:0] == 2'b11) |=>
      tx_count_bytes == 12'($past(tx_len)) + 12'h014)
      else $error("egress byte charge wrong with gap and preamble");
   a_pre_only: assert property (@(posedge clk) disable iff (!resetn)
      (rx_frame && r.acc[rx_port][1:0] == 2'b01) |=>
      rx_count_bytes == 12'($past(rx_len)) + 12'h008)
      else $error("ingress byte charge wrong with preamble");
   a_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
      (rd_acc && idx == IDX_RATE_ACC_B) |=> prdata[7:5] == 3'h0)
      else $error("reserved accounting bits not zero");
   a_split_kept: assert property (@(posedge clk) disable iff (!resetn)
      r.split != 2'h3) else $error("reserved split stored");
   a_q0_reset: assert property (@(posedge clk)
      $rose(resetn) |-> r.q0w[0] == Q0_WEIGHT_RST)
      else $error("queue 0 weight reset wrong");
endmodule : pqw_top

// *** verification/tb_top.sv ***
// self-checking bench for the queue weight and rate accounting block
// assumes pqw_pkg and pqw_top are compiled first; apb slave answers with pready high
module tb_top
   import pqw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // signals
   logic clk, resetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err;
   logic [1:0] rx_port, tx_port, rx_count_port, tx_count_port;
   logic rx_frame, rx_bcast, rx_mcast, rx_flood, tx_frame, q_tx_done;
   logic rx_count_vld, rx_counted, tx_count_vld;
   logic [10:0] rx_len, tx_len;
   logic [3:0] rx_over, q_avail, q_grant, flow_ctrl, fc_mask;
   logic [11:0] rx_count_bytes, tx_count_bytes;
   int num_errors = 0;
   int total_checks = 0;
   int seed = 60;
   int exp_bytes;
   bit exp_cnt;
   pqw_top u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_port(rx_port), .rx_frame(rx_frame), .rx_len(rx_len), .rx_bcast(rx_bcast),
      .rx_mcast(rx_mcast), .rx_flood(rx_flood), .rx_over(rx_over), .tx_port(tx_port),
      .tx_frame(tx_frame), .tx_len(tx_len), .q_avail(q_avail), .q_tx_done(q_tx_done),
      .q_grant(q_grant), .flow_ctrl(flow_ctrl), .rx_count_vld(rx_count_vld),
      .rx_counted(rx_counted), .rx_count_bytes(rx_count_bytes), .rx_count_port(rx_count_port),
      .tx_count_vld(tx_count_vld), .tx_count_bytes(tx_count_bytes),
      .tx_count_port(tx_count_port));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ==========================================
   // shared tasks
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   // one apb transfer; read data and error are taken at the edge that samples pready
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) begin
         num_errors++;
         conclude();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk("register", exp, rd);
   endtask : rchk
   // the grant must appear within a bounded wait, then one packet is sent from it
   task automatic gnt(input logic [3:0] exp);
      int n;
      n = 0;
      while (q_grant === 4'h0 && n < 50) begin
         @(negedge clk);
         n++;
      end
      chk("grant", {28'h0, exp}, {28'h0, q_grant});
      @(posedge clk);
      q_tx_done <= 1'b1;
      @(posedge clk);
      q_tx_done <= 1'b0;
      @(posedge clk);
   endtask : gnt
   // ==========================================
   // main sequence
   initial begin
      resetn = 1'b0;
      {psel, penable, pwrite, rx_frame, tx_frame, q_tx_done} = 6'h00;
      {rx_bcast, rx_mcast, rx_flood} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      {rx_port, tx_port} = 4'h0;
      {rx_len, tx_len} = 22'h0;
      {rx_over, q_avail} = 8'h00;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      for (int p = 0; p < 4; p++) begin
         rchk(8'hC5 + 8'(16 * p), 32'h81);
         rchk(8'hC6 + 8'(16 * p), 32'h00);
      end
      rchk(8'hC4, 32'h82);
      apb(1'b1, 8'hD6, 32'hFF);
      rchk(8'hD6, 32'h1F);
      apb(1'b0, 8'hB0, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      $display("test registers done");
      // every limit mode with every gap and preamble setting, random frame kinds
      for (int m = 0; m < 4; m++) begin
         for (int g = 0; g < 4; g++) begin
            @(posedge clk);
            rx_port <= 2'($random(seed));
            @(posedge clk);
            apb(1'b1, 8'hC6 + 8'(16 * rx_port), {28'h0, 2'(m), 2'(g)});
            @(posedge clk);
            {rx_bcast, rx_mcast, rx_flood} <= 3'($random(seed));
            rx_len <= 11'($random(seed));
            tx_len <= 11'($random(seed));
            tx_port <= rx_port;
            rx_frame <= 1'b1;
            tx_frame <= 1'b1;
            @(posedge clk);
            rx_frame <= 1'b0;
            tx_frame <= 1'b0;
            @(negedge clk);
            exp_cnt = (m == 0) || (m == 1 && (rx_bcast || rx_mcast || rx_flood))
               || (m == 2 && (rx_bcast || rx_mcast)) || (m == 3 && rx_bcast);
            exp_bytes = (g[1] ? 12 : 0) + (g[0] ? 8 : 0);
            chk("rx valid", 32'h1, {31'h0, rx_count_vld});
            chk("rx counted", {31'h0, exp_cnt}, {31'h0, rx_counted});
            chk("rx bytes", 32'(rx_len) + 32'(exp_bytes), 32'(rx_count_bytes));
            chk("rx port", 32'(rx_port), 32'(rx_count_port));
            chk("tx valid", 32'h1, {31'h0, tx_count_vld});
            chk("tx bytes", 32'(tx_len) + 32'(exp_bytes), 32'(tx_count_bytes));
         end
      end
      $display("test accounting done");
      fc_mask = 4'($random(seed));
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, 8'hC6 + 8'(16 * p), {27'h0, fc_mask[p], 4'h0});
      end
      @(posedge clk);
      rx_over <= 4'hF;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("flow control", {28'h0, fc_mask}, {28'h0, flow_ctrl});
      rx_over <= 4'h0;
      $display("test flow control done");
      apb(1'b1, 8'hC1, 32'h2);
      apb(1'b1, 8'hC1, 32'h3);
      rchk(8'hC1, 32'h2);
      @(posedge clk);
      q_avail <= 4'h3;
      gnt(4'h2);
      gnt(4'h2);
      gnt(4'h1);
      // drop availability at once so no fresh grant is left hanging
      q_avail <= 4'h0;
      apb(1'b1, 8'hC5, 32'h01);
      @(posedge clk);
      q_avail <= 4'h1;
      for (int k = 0; k < 3; k++) begin
         gnt(4'h1);
      end
      $display("test scheduler done");
      conclude();
   end
   initial begin
      #3000000;
      num_errors++;
      conclude();
   end
endmodule : tb_top
